/* rtl/aas_pkg.sv */
`default_nettype none
package aas_pkg;
  // clock and pacing
  localparam int CLK_HZ = 50000000;
  localparam int CONT_MAX_SPS = 1200;
  localparam int BURST_MAX_SPS = 8000;
  // least period per aggregate sample, rounded up to whole cycles
  localparam int CONT_PERIOD_CYC = (CLK_HZ + CONT_MAX_SPS - 1) / CONT_MAX_SPS;
  localparam int BURST_PERIOD_CYC = (CLK_HZ + BURST_MAX_SPS - 1) / BURST_MAX_SPS;
  localparam int FIFO_DEPTH = 4096;
  localparam int SCAN_MAX = 8;
  // led timing
  localparam int LED_FAST_HZ = 8;
  localparam int LED_SLOW_HZ = 1;
  localparam int LED_FAST_CYC = CLK_HZ / (2 * LED_FAST_HZ);
  localparam int LED_SLOW_CYC = CLK_HZ / (2 * LED_SLOW_HZ);
  localparam int LED_HELLO_TOGGLES = 6;
  // result widths
  localparam int SE_BITS = 11;
  localparam int DIFF_BITS = 12;
  localparam int SE_CHANNELS = 8;
  localparam int DIFF_CHANNELS = 4;
  // mode encodings
  localparam logic [1:0] MODE_SOFT = 2'h0;
  localparam logic [1:0] MODE_CONT = 2'h1;
  localparam logic [1:0] MODE_BURST = 2'h2;
  localparam logic [2:0] GAIN_SE_FIXED = 3'h1;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ARMED = 5'h02,
    ST_RUN = 5'h04,
    ST_CONV = 5'h08,
    ST_DRAIN = 5'h10
  } aas_state_type;
endpackage : aas_pkg
`default_nettype wire

/* rtl/aas_sequencer.sv */
// What this block does
// [RULE_01] soft mode: one conversion per command, one result
// [RULE_02] host keeps soft pacing at or below 50 S/s
// [RULE_03] continuous: convert scan list into fifo until stop
// [RULE_04] continuous aggregate rate at most 1.2 kS/s
// [RULE_05] continuous starts on command or external trigger
// [RULE_06] continuous: fifo drained to host while converting
// [RULE_07] burst: one capture of up to 4096 samples
// [RULE_08] burst aggregate rate at most 8 kS/s
// [RULE_09] after burst, fifo contents delivered to host
// [RULE_10] led steady while attached and nothing else
// [RULE_11] led blinks while data moves
// [RULE_12] led blinks three times on first contact
// [RULE_13] led slow blink while armed, steady on trigger
// [RULE_14] no control can disable the led
// [RULE_15] eight 11-bit single-ended or four 12-bit differential
// [RULE_16] single-ended uses one fixed range only
// [RULE_17] differential gain picks one of eight ranges
// [RULE_18] differential result is positive minus negative leg
// [RULE_19] fifo full in continuous: overrun flag, stop
// [RULE_20] pacing timer steps scan list, wraps at end
`default_nettype none
module aas_sequencer #(
  parameter int FIFO_DEPTH = aas_pkg::FIFO_DEPTH,
  parameter int CONT_PERIOD_CYC = aas_pkg::CONT_PERIOD_CYC,
  parameter int BURST_PERIOD_CYC = aas_pkg::BURST_PERIOD_CYC,
  parameter int LED_FAST_CYC = aas_pkg::LED_FAST_CYC,
  parameter int LED_SLOW_CYC = aas_pkg::LED_SLOW_CYC
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  // host commands
  input wire logic [1:0] mode_in,
  input wire logic start_in,
  input wire logic stop_in,
  input wire logic use_trigger_in,
  input wire logic trigger_high_in,
  input wire logic external_trigger_input_in,
  input wire logic differential_in,
  input wire logic [2:0] programmable_gain_stage_in,
  input wire logic [3:0] scan_len_in,
  input wire logic [23:0] scan_list_in,
  input wire logic [11:0] burst_count_in,
  input wire logic attached_in,
  input wire logic overrun_clear_in,
  // converter
  output logic conv_start_out,
  output logic [2:0] conv_pos_chan_out,
  output logic [2:0] conv_neg_chan_out,
  output logic conv_diff_out,
  output logic [2:0] conv_gain_out,
  input wire logic conv_done_in,
  input wire logic [11:0] conv_pos_in,
  input wire logic [11:0] conv_neg_in,
  // samples to host
  output logic host_valid_out,
  output logic [12:0] host_data_out,
  output logic [2:0] host_chan_out,
  input wire logic host_ready_in,
  // status
  output logic busy_out,
  output logic armed_out,
  output logic overrun_out,
  output logic led_out
);
  localparam int AW = $clog2(FIFO_DEPTH);
  typedef struct packed {
    aas_pkg::aas_state_type st;
    logic [1:0] mode;
    logic [31:0] pace;
    logic [2:0] idx;
    logic [AW:0] wp;
    logic [AW:0] rp;
    logic [12:0] remain;
    logic conv;
    logic [2:0] pch;
    logic [2:0] nch;
    logic cdiff;
    logic [2:0] cgain;
    logic hv;
    logic [12:0] hd;
    logic [2:0] hc;
    logic ovr;
    logic was_att;
    logic [3:0] hello;
    logic [31:0] ledc;
    logic led;
    logic busy;
    logic armed;
  } aas_regs_type;
  aas_regs_type q, d;
  logic [15:0] mem [FIFO_DEPTH];
  logic fifo_wr;
  logic [15:0] fifo_wdata;
  logic [AW:0] fill;
  logic trig_hit;
  logic [12:0] result;

  // ==========================================================
  // helpers
  function automatic logic [2:0] list_entry(input logic [23:0] l, input logic [2:0] i);
    list_entry = l[3*i +: 3];
  endfunction : list_entry

  // ==========================================================
  // next state
  always_comb begin
    d = q;
    fifo_wr = 1'b0;
    fill = q.wp - q.rp;
    trig_hit = (external_trigger_input_in == trigger_high_in);
    // single-ended 11-bit, differential 13-bit signed difference
    if (q.cdiff) begin
      result = 13'(signed'({1'b0, conv_pos_in}) - signed'({1'b0, conv_neg_in})); // RULE_18 RULE_15
    end else begin
      result = {2'h0, conv_pos_in[aas_pkg::DIFF_BITS-1 -: aas_pkg::SE_BITS]}; // RULE_15
    end
    fifo_wdata = {q.idx, result};
    d.conv = 1'b0;
    if (q.hv && host_ready_in) begin
      d.hv = 1'b0;
    end
    if (overrun_clear_in) begin
      d.ovr = 1'b0;
    end
    case (q.st)
      aas_pkg::ST_IDLE: begin
        d.idx = 3'h0;
        if (start_in) begin
          d.mode = mode_in;
          d.remain = {1'b0, burst_count_in} + 13'h1; // RULE_07
          d.wp = '0;
          d.rp = '0;
          d.pace = '0;
          if (mode_in == aas_pkg::MODE_SOFT) begin
            d.st = aas_pkg::ST_CONV;
            d.conv = 1'b1; // RULE_01
          end else if (use_trigger_in) begin
            d.st = aas_pkg::ST_ARMED;
          end else begin
            d.st = aas_pkg::ST_RUN; // RULE_05
          end
        end
      end
      aas_pkg::ST_ARMED: begin
        if (stop_in) begin
          d.st = aas_pkg::ST_IDLE;
        end else if (trig_hit) begin
          d.st = aas_pkg::ST_RUN; // RULE_05 RULE_07
        end
      end
      aas_pkg::ST_CONV: begin
        if (conv_done_in) begin
          d.hv = 1'b1;
          d.hd = result;
          d.hc = q.pch;
          d.st = aas_pkg::ST_IDLE; // RULE_01
        end
      end
      aas_pkg::ST_RUN: begin
        if (conv_done_in) begin
          if (fill == (AW+1)'(FIFO_DEPTH)) begin
            d.ovr = 1'b1; // RULE_19
            d.st = aas_pkg::ST_DRAIN;
          end else begin
            fifo_wr = 1'b1; // RULE_03
            d.wp = q.wp + 1'b1;
            if (q.mode == aas_pkg::MODE_BURST) begin
              d.remain = q.remain - 13'h1;
            end
          end
          // compared at four bits so a full list of eight still wraps at its end
          d.idx = ({1'b0, q.idx} + 4'h1 >= scan_len_in || scan_len_in == 4'h0) ? 3'h0 :
                  q.idx + 3'h1; // RULE_20
        end
        if (stop_in || (q.mode == aas_pkg::MODE_BURST && q.remain == 13'h0)) begin
          d.st = aas_pkg::ST_DRAIN; // RULE_09
        end else if (q.pace == 32'h0) begin
          d.conv = 1'b1; // RULE_20
          d.pace = (q.mode == aas_pkg::MODE_BURST) ? 32'(BURST_PERIOD_CYC - 1) :
                   32'(CONT_PERIOD_CYC - 1); // RULE_04 RULE_08
        end else begin
          d.pace = q.pace - 32'h1;
        end
      end
      aas_pkg::ST_DRAIN: begin
        if (q.rp == q.wp && !q.hv) begin
          d.st = aas_pkg::ST_IDLE;
        end
      end
      default: d.st = aas_pkg::ST_IDLE;
    endcase
    // streaming out during continuous runs, and after bursts
    if ((!q.hv || host_ready_in) && q.rp != q.wp && (q.st == aas_pkg::ST_DRAIN ||
        (q.st == aas_pkg::ST_RUN && q.mode == aas_pkg::MODE_CONT))) begin
      d.hv = 1'b1; // RULE_06 RULE_09
      d.hd = mem[q.rp[AW-1:0]][12:0];
      d.hc = mem[q.rp[AW-1:0]][15:13];
      d.rp = q.rp + 1'b1;
    end
    if (d.conv) begin
      d.pch = (mode_in == aas_pkg::MODE_SOFT && q.st == aas_pkg::ST_IDLE) ?
              list_entry(scan_list_in, 3'h0) : list_entry(scan_list_in, q.idx);
      d.cdiff = differential_in;
      if (differential_in) begin
        d.pch = {1'b0, d.pch[1:0]};
        d.nch = {1'b1, d.pch[1:0]}; // RULE_18
        d.cgain = programmable_gain_stage_in; // RULE_17
      end else begin
        d.nch = 3'h0;
        d.cgain = aas_pkg::GAIN_SE_FIXED; // RULE_16
      end
    end
    // ========================================================
    // status led, running in every state while attached, held off while detached
    d.was_att = attached_in;
    if (attached_in && !q.was_att) begin
      d.hello = 4'(aas_pkg::LED_HELLO_TOGGLES); // RULE_12
      d.ledc = '0;
    end
    if (!attached_in) begin
      d.led = 1'b0;
      d.hello = 4'h0;
    end else if (q.hello != 4'h0 || q.st == aas_pkg::ST_ARMED || q.hv) begin
      if (q.ledc == 32'h0) begin
        d.led = ~q.led; // RULE_11 RULE_13
        if (q.hello != 4'h0) begin
          d.hello = q.hello - 4'h1; // RULE_12
        end
        d.ledc = (q.st == aas_pkg::ST_ARMED && q.hello == 4'h0) ?
                 32'(LED_SLOW_CYC - 1) : 32'(LED_FAST_CYC - 1);
      end else begin
        d.ledc = q.ledc - 32'h1;
      end
    end else begin
      d.led = 1'b1; // RULE_10 RULE_13 RULE_14
    end
    // status flags registered with the state so the pins come from flops
    d.busy = (d.st != aas_pkg::ST_IDLE);
    d.armed = (d.st == aas_pkg::ST_ARMED);
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      q <= '{st: aas_pkg::ST_IDLE, mode: aas_pkg::MODE_SOFT, default: '0};
    end else begin
      q <= d;
    end
    if (fifo_wr) begin
      mem[q.wp[AW-1:0]] <= fifo_wdata;
    end
  end

  assign conv_start_out = q.conv;
  assign conv_pos_chan_out = q.pch;
  assign conv_neg_chan_out = q.nch;
  assign conv_diff_out = q.cdiff;
  assign conv_gain_out = q.cgain;
  assign host_valid_out = q.hv;
  assign host_data_out = q.hd;
  assign host_chan_out = q.hc;
  assign busy_out = q.busy;
  assign armed_out = q.armed;
  assign overrun_out = q.ovr;
  assign led_out = q.led;

  // ==========================================================
  // checks
  property p_one_conv;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      (q.st == aas_pkg::ST_CONV) |-> !q.conv || $past(q.st) == aas_pkg::ST_IDLE;
  endproperty
  a_one_conv: assert property (p_one_conv) else $error("extra soft conversion"); // RULE_01
  property p_pace;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      q.conv && q.st == aas_pkg::ST_RUN |=> !q.conv [*8];
  endproperty
  a_pace: assert property (p_pace) else $error("conversions too close"); // RULE_04
  property p_ovr;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      $rose(q.ovr) |-> q.st == aas_pkg::ST_DRAIN;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun did not stop scan"); // RULE_19
  property p_se_gain;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      $past(q.conv) && !q.cdiff |-> q.cgain == aas_pkg::GAIN_SE_FIXED;
  endproperty
  a_se_gain: assert property (p_se_gain) else $error("single-ended range changed"); // RULE_16
  property p_led_idle;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      attached_in && $past(attached_in) && q.hello == 4'h0 && q.st == aas_pkg::ST_IDLE
      && !q.hv |=> q.led;
  endproperty
  a_led_idle: assert property (p_led_idle) else $error("led not steady"); // RULE_10
  property p_hello;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      attached_in && !q.was_att |=> q.hello == 4'(aas_pkg::LED_HELLO_TOGGLES);
  endproperty
  a_hello: assert property (p_hello) else $error("no greeting blinks"); // RULE_12
  property p_diff_leg;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      q.conv && q.cdiff |-> q.nch == {1'b1, q.pch[1:0]};
  endproperty
  a_diff_leg: assert property (p_diff_leg) else $error("bad negative leg"); // RULE_18
  property p_burst_end;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      q.st == aas_pkg::ST_RUN && q.mode == aas_pkg::MODE_BURST && q.remain == 13'h0
      |=> q.st == aas_pkg::ST_DRAIN;
  endproperty
  a_burst_end: assert property (p_burst_end) else $error("burst did not end"); // RULE_07
  property p_soft_answer;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      q.st == aas_pkg::ST_CONV && conv_done_in |=> q.hv && q.st == aas_pkg::ST_IDLE;
  endproperty
  a_soft_answer: assert property (p_soft_answer) else $error("soft result not returned"); // RULE_01
  property p_ovr_hold;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      q.ovr && !overrun_clear_in |=> q.ovr;
  endproperty
  a_ovr_hold: assert property (p_ovr_hold) else $error("overrun flag lost"); // RULE_19
  property p_trig_start;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      q.st == aas_pkg::ST_ARMED && !stop_in && trig_hit |=> q.st == aas_pkg::ST_RUN;
  endproperty
  a_trig_start: assert property (p_trig_start) else $error("trigger did not start scan"); // RULE_05
  property p_hv_hold;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      q.hv && !host_ready_in && q.st != aas_pkg::ST_CONV |=> q.hv && $stable(q.hd);
  endproperty
  a_hv_hold: assert property (p_hv_hold) else $error("sample dropped before taken"); // RULE_06
  property p_cont_stop;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      q.st == aas_pkg::ST_RUN && stop_in |=> q.st == aas_pkg::ST_DRAIN && !q.conv;
  endproperty
  a_cont_stop: assert property (p_cont_stop) else $error("scan ran past stop"); // RULE_03
  property p_led_run;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      attached_in && q.st == aas_pkg::ST_RUN && q.hello == 4'h0 && !q.hv |=> q.led;
  endproperty
  a_led_run: assert property (p_led_run) else $error("led not steady after trigger"); // RULE_13
endmodule : aas_sequencer
`default_nettype wire

/* testbench/aas_host_model.sv */
`default_nettype none
// ==========
// converter and host stand-in
module aas_host_model (
  // clock
  input wire logic clk_sys_in,
  // bench control
  input wire logic stall_in,
  input wire logic [7:0] rnd_in,
  // converter side
  input wire logic conv_start_in,
  output logic conv_done_out,
  output logic [11:0] conv_pos_out,
  output logic [11:0] conv_neg_out,
  // host side
  output logic host_ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_q = 0;
  int n_q = 0;
  initial begin
    conv_done_out = 1'b0;
    conv_pos_out = 12'h0;
    conv_neg_out = 12'h0;
    host_ready_out = 1'b0;
    forever begin
      @(posedge clk_sys_in);
      #1;
      host_ready_out = !stall_in && rnd_in[0];
      conv_done_out = 1'b0;
      // idle code lines toggle so a stale value never passes
      conv_pos_out = ~conv_pos_out;
      conv_neg_out = ~conv_neg_out;
      if (wait_q == 1) begin
        conv_done_out = 1'b1;
        conv_pos_out = 12'h400 + 12'(n_q * 37);
        conv_neg_out = 12'h300 + 12'(n_q * 53);
        n_q++;
      end
      if (wait_q > 0) wait_q--;
      else if (conv_start_in === 1'b1) wait_q = 2 + int'(rnd_in[2:1]);
    end
  end
endmodule : aas_host_model
`default_nettype wire

/* testbench/test_aas_sequencer.sv */
`default_nettype none
module test_aas_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // stimulus and probes
  logic clk = 0, rst_n = 0, start = 0, stop = 0, use_trig = 0, trig_hi = 0, ext = 0;
  logic diff = 0, att = 0, oclr = 0, stall = 0, track = 1, cs, cdiff, done, hv, hr;
  logic busy, armed, ovr, led, led_p = 0;
  logic [1:0] mode = 0;
  logic [2:0] programmable_gain_stage = 0, pch, nch, cgain, hc, eg;
  logic [3:0] slen = 1;
  logic [23:0] slist = 0;
  logic [11:0] bcnt = 0, pos, neg;
  logic [12:0] hd;
  logic [16:0] nt;
  logic [16:0] notes[$];
  logic [31:0] seed = 32'h134f4ece;
  logic [7:0] rnd = 0;
  int fail_count = 0, compares = 0, cyc = 0, last = 0, idx = 0, cur = 0;
  int nstart = 0, ndone = 0, ntog = 0, k, s0, n0;
  aas_sequencer #(.FIFO_DEPTH(16), .CONT_PERIOD_CYC(20), .BURST_PERIOD_CYC(10),
    .LED_FAST_CYC(8), .LED_SLOW_CYC(16)) dut (
    .clk_sys_in(clk), .reset_n_in(rst_n), .mode_in(mode), .start_in(start),
    .stop_in(stop), .use_trigger_in(use_trig), .trigger_high_in(trig_hi),
    .external_trigger_input_in(ext), .differential_in(diff),
    .programmable_gain_stage_in(programmable_gain_stage), .scan_len_in(slen), .scan_list_in(slist),
    .burst_count_in(bcnt), .attached_in(att), .overrun_clear_in(oclr),
    .conv_start_out(cs), .conv_pos_chan_out(pch), .conv_neg_chan_out(nch),
    .conv_diff_out(cdiff), .conv_gain_out(cgain), .conv_done_in(done),
    .conv_pos_in(pos), .conv_neg_in(neg), .host_valid_out(hv), .host_data_out(hd),
    .host_chan_out(hc), .host_ready_in(hr), .busy_out(busy), .armed_out(armed),
    .overrun_out(ovr), .led_out(led));
  aas_host_model host (.clk_sys_in(clk), .stall_in(stall), .rnd_in(rnd),
    .conv_start_in(cs), .conv_done_out(done), .conv_pos_out(pos),
    .conv_neg_out(neg), .host_ready_out(hr));
  initial forever #10 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  always @(posedge clk) begin
    seed <= xs(seed);
    rnd <= seed[7:0];
  end
  // ==========
  // tasks
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic print_verdict();
    $display("counts: compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  task automatic go(input logic [1:0] m);
    mode = m;
    idx = 0;
    last = -1000;
    start = 1;
    step(1);
    start = 0;
  endtask : go
  task automatic wait_done(input int t);
    int j;
    j = 0;
    while (ndone < t && j < 900) begin
      step(1);
      j++;
    end
  endtask : wait_done
  task automatic drain();
    int j;
    j = 0;
    while ((notes.size() != 0 || hv !== 1'b0) && j < 900) begin
      step(1);
      j++;
    end
    // one more edge so the state falls back to idle
    step(1);
    chk(16'(notes.size()), 16'h0);
  endtask : drain
  // ==========
  // watchers: converter side, then host side against the notes
  always @(posedge clk) begin
    cyc++;
    if (led !== led_p) ntog++;
    led_p = led;
    if (cs === 1'b1) begin
      nstart++;
      eg = diff ? programmable_gain_stage : aas_pkg::GAIN_SE_FIXED;
      chk(16'(pch), 16'(slist[idx*3+:3]));
      if (diff) chk(16'(nch), 16'(pch) + 16'h4);
      chk(16'({cdiff, cgain}), 16'({diff, eg}));
      if (mode != aas_pkg::MODE_SOFT) begin
        chk(16'(cyc - last >= (mode == aas_pkg::MODE_CONT ? 20 : 10)), 16'h1);
        cur = idx;
        idx = (idx + 1) % int'(slen);
      end
      last = cyc;
    end
    if (done === 1'b1) begin
      ndone++;
      if (track) notes.push_back({!diff, mode == aas_pkg::MODE_SOFT ? slist[2:0] : 3'(cur),
        diff ? 13'({1'b0, pos} - {1'b0, neg}) : 13'h0});
    end
    if (hv === 1'b1 && hr === 1'b1 && track) begin
      if (notes.size() == 0) chk(16'h0, 16'h1);
      else begin
        nt = notes.pop_front();
        chk(16'(hc), 16'(nt[15:13]));
        if (nt[16]) chk(16'(hd[12:11]), 16'h0);
        else chk(16'(hd), 16'(nt[12:0]));
      end
    end
    // the whole run needs well under this many cycles
    if (cyc > 20000) begin
      fail_count++;
      print_verdict();
    end
  end
  // ==========
  // scenarios
  initial begin
    step(4);
    rst_n = 1;
    step(1);
    chk(16'({busy, armed, ovr, led}), 16'h0);
    att = 1;
    ntog = 0;
    step(80);
    chk(16'(ntog >= 6), 16'h1);
    chk(16'(led), 16'h1);
    $display("test led greeting done");
    for (int i = 0; i < 4; i++) begin
      diff = i[0];
      programmable_gain_stage = seed[2:0];
      slist = {seed[26:6], diff ? {1'b0, seed[4:3]} : seed[5:3]};
      n0 = ndone;
      s0 = nstart;
      go(aas_pkg::MODE_SOFT);
      wait_done(n0 + 1);
      drain();
      chk(16'(nstart - s0), 16'h1);
    end
    $display("test soft paced done");
    diff = 0;
    slen = 4'h3;
    slist = {15'h0, 3'h7, 3'h2, 3'h5};
    n0 = ndone;
    ntog = 0;
    go(aas_pkg::MODE_CONT);
    wait_done(n0 + 7);
    stop = 1;
    step(1);
    stop = 0;
    s0 = nstart;
    step(60);
    chk(16'(nstart - s0), 16'h0);
    drain();
    chk(16'({busy, ntog > 0}), 16'h1);
    $display("test continuous scan done");
    stall = 1;
    track = 0;
    slen = 4'h8;
    go(aas_pkg::MODE_CONT);
    k = 0;
    while (ovr !== 1'b1 && k < 900) begin
      step(1);
      k++;
    end
    step(3);
    // conversions stop but the captured words still wait for the host
    chk(16'({ovr, busy}), 16'h3);
    stall = 0;
    drain();
    oclr = 1;
    step(1);
    oclr = 0;
    step(1);
    chk(16'(ovr), 16'h0);
    track = 1;
    $display("test overrun done");
    for (int p = 0; p < 2; p++) begin
      trig_hi = p[0];
      ext = !p[0];
      use_trig = 1;
      diff = 1;
      stall = 1;
      programmable_gain_stage = seed[2:0];
      slen = 4'h2;
      slist = {18'h0, 3'h3, 3'h1};
      bcnt = 12'h4;
      n0 = ndone;
      s0 = nstart;
      go(aas_pkg::MODE_BURST);
      ntog = 0;
      step(48);
      chk(16'({armed, nstart != s0}), 16'h2);
      chk(16'(ntog inside {[2:4]}), 16'h1);
      ext = p[0];
      wait_done(n0 + 5);
      chk(16'(armed), 16'h0);
      step(40);
      chk(16'(nstart - s0), 16'h5);
      stall = 0;
      drain();
      chk(16'(busy), 16'h0);
    end
    use_trig = 0;
    $display("test triggered burst done");
    print_verdict();
  end
endmodule : test_aas_sequencer
`default_nettype wire
